// ==== shared/rrd_pkg.sv ====
// shared constants and types for the beat detector and sample buffer block
package rrd_pkg;

    // serial frame layout
    localparam int          CMD_BITS      = 8;
    localparam int          FRAME_BITS    = 32;
    localparam int          WORD_BITS     = 24;
    localparam logic [5:0]  CNT_CMD_LAST  = 6'h07;
    localparam logic [5:0]  CNT_DATA_0    = 6'h08;
    localparam logic [5:0]  CNT_FRAME_END = 6'h1F;
    localparam logic [5:0]  CNT_DONE      = 6'h20;

    // register addresses, bits 7:1 of the command byte; bit 0 high reads
    localparam logic [6:0]  ADDR_CFG_A    = 7'h1D;
    localparam logic [6:0]  ADDR_CFG_B    = 7'h1E;
    localparam logic [6:0]  ADDR_BURST    = 7'h20;
    localparam logic [6:0]  ADDR_SINGLE   = 7'h21;
    localparam logic [6:0]  ADDR_INTERVAL = 7'h25;

    // writable bits and reset values of the two configuration words
    localparam logic [23:0] CFG_A_MASK    = 24'hFFBF00;
    localparam logic [23:0] CFG_B_MASK    = 24'h3F3700;
    localparam logic [23:0] CFG_A_RESET   = 24'h3F2300;
    localparam logic [23:0] CFG_B_RESET   = 24'h202400;

    // field positions, first word
    localparam int          WIN_LSB       = 20;
    localparam int          GAIN_LSB      = 16;
    localparam int          EN_BIT        = 15;
    localparam int          PAVG_LSB      = 12;
    localparam int          PTSF_LSB      = 8;
    // field positions, second word
    localparam int          HOFF_LSB      = 16;
    localparam int          RAVG_LSB      = 12;
    localparam int          RHSF_LSB      = 8;

    // detector constants
    localparam logic [5:0]  WIN_BASE      = 6'h06;
    localparam logic [3:0]  GAIN_AUTO     = 4'hF;
    localparam logic [13:0] INTERVAL_MAX  = 14'h3FFF;
    localparam logic [23:0] SCALED_MAX    = 24'hFFFFFF;

    // sample buffer
    localparam int          FIFO_DEPTH    = 32;
    localparam int          FIFO_AW       = 5;
    localparam logic [5:0]  FIFO_FULL     = 6'h20;

    // sample tags
    localparam logic [2:0]  TAG_VALID     = 3'h0;
    localparam logic [2:0]  TAG_FAST      = 3'h1;
    localparam logic [2:0]  TAG_LAST_BIT  = 3'h2;
    localparam logic [2:0]  TAG_EMPTY     = 3'h6;
    localparam logic [2:0]  TAG_OVERFLOW  = 3'h7;

    typedef enum logic [0:0] {
        DET_IDLE   = 1'b0,
        DET_WINDOW = 1'b1
    } rrd_det_state_type;

endpackage

// ==== shared/rrd_mem_if.sv ====
// write and read port bundle between the block and its sample memory
`timescale 1ns/1ps
`default_nettype none
interface rrd_mem_if;
    import rrd_pkg::*;
    logic                 wr_en;
    logic [FIFO_AW-1:0]   wr_addr;
    logic [WORD_BITS-1:0] wr_data;
    logic [FIFO_AW-1:0]   rd_addr;
    logic [WORD_BITS-1:0] rd_data;

    modport owner (output wr_en, output wr_addr, output wr_data,
                   output rd_addr, input rd_data);
    modport store (input wr_en, input wr_addr, input wr_data,
                   input rd_addr, output rd_data);
endinterface
`default_nettype wire

// ==== design/rrd_link_sync.sv ====
// two-flop synchroniser for the serial link pins
`timescale 1ns/1ps
`default_nettype none
module rrd_link_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             i_ref_clk,
    input  wire logic             i_reset,
    input  wire logic [WIDTH-1:0] i_async,
    output var  logic [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } rrd_sync_state_type;

    rrd_sync_state_type s;
    rrd_sync_state_type next_s;

    // meta stage feeds only the stable stage
    always_comb begin
        next_s        = s;
        next_s.meta   = i_async;
        next_s.stable = s.meta;
    end

    // chip select idles high so reset loads the deselected level
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            s <= '1;
        end else begin
            s <= next_s;
        end
    end

    assign o_sync = s.stable;
endmodule // rrd_link_sync
`default_nettype wire

// ==== design/rrd_sample_mem.sv ====
// sample buffer storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module rrd_sample_mem (
    input  wire logic     i_ref_clk,
    input  wire logic     i_reset,
    rrd_mem_if.store      mem
);
    import rrd_pkg::*;

    typedef struct packed {
        logic [FIFO_DEPTH-1:0][WORD_BITS-1:0] cells;
        logic [WORD_BITS-1:0]                 rd_data;
    } rrd_mem_state_type;

    rrd_mem_state_type s;
    rrd_mem_state_type next_s;

    // read first: the read returns the old contents of the addressed cell
    always_comb begin
        next_s         = s;
        next_s.rd_data = s.cells[mem.rd_addr];
        if (mem.wr_en) begin
            next_s.cells[mem.wr_addr] = mem.wr_data;
        end
    end

    // contents need no reset; only the read register is cleared
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            s.rd_data <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign mem.rd_data = s.rd_data;
endmodule // rrd_sample_mem
`default_nettype wire

// ==== design/rrd_beat_fifo.sv ====
// beat interval detector configuration and 32-entry cardiac sample buffer
//
// Function
// - two read/write detector configuration words: gains/thresholds, then timing
// - averaging window is 6+2*code time units, code resets to 0011
// - detector input scaled by two to the gain code, 1111 auto, reset 1111; auto keeps unity gain, no range search
// - detection runs only with enable bit 15 and channel enable both set
// - peak average = (peak + (W-1)*average)/W, W=2,4,8,16, code reset 10
// - peak threshold = peak average*(code+1)/16, code resets to 0011
// - static hold-off = 6-bit code (reset 32) times detector time unit
// - hold-off used is the larger of static and dynamic hold-off
// - interval average = (interval + (W-1)*average)/W, code resets to 10
// - dynamic hold-off = interval average*code/8, code 000 disables it
// - samples kept in a 32-entry, 24-bit circular buffer with pointers
// - read pointer moves on rising edge 32, burst also every 24 more
// - a sample whose read moved the pointer is never returned again
// - buffer interrupt when unread entries reach threshold 1 to 32
// - full buffer receiving a write with no same-cycle read sets overflow flag and overflow tag
// - sample word: voltage 23:6, sample tag 5:3, pace tag 2:0
// - interval read: 14-bit interval in 23:10, lower bits zero
// - tags: 000 valid, 001 fast, 010/011 last, 110 empty, 111 overflow
// - each new beat refreshes the interval and raises interval interrupt
`timescale 1ns/1ps
`default_nettype none
module rrd_beat_fifo (
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset,
    input  wire logic        i_sclk,
    input  wire logic        i_csb_n,
    input  wire logic        i_sdi,
    output var  logic        o_sdo,
    output var  logic        o_sdo_oe,
    input  wire logic        i_sample_valid,
    input  wire logic [17:0] i_sample_voltage,
    input  wire logic        i_sample_fast,
    input  wire logic [2:0]  i_pace_tag,
    input  wire logic        i_channel_enable,
    input  wire logic        i_beat_tick,
    input  wire logic        i_fifo_clear,
    input  wire logic [5:0]  i_fifo_irq_threshold,
    input  wire logic        i_beat_irq_clear,
    output var  logic        o_fifo_irq,
    output var  logic        o_fifo_overflow_flag,
    output var  logic        o_beat_interval_irq
);
    import rrd_pkg::*;

    typedef struct packed {
        logic                  sclk_prev;
        logic [7:0]            cmd;
        logic [23:0]           din;
        logic [5:0]            bit_cnt;
        logic                  is_read;
        logic                  burst;
        logic                  reload_pend;
        logic                  word_valid;
        logic [23:0]           shreg;
        logic                  sdo;
        logic                  sdo_oe;
        logic [23:0]           cfg_a;
        logic [23:0]           cfg_b;
        logic [4:0]            wr_ptr;
        logic [4:0]            rd_ptr;
        logic [5:0]            count;
        logic                  ovf;
        logic                  fifo_irq;
        logic [13:0]           beat_interval;
        logic                  beat_irq;
        logic [23:0]           peak_avg;
        logic [13:0]           int_avg;
        logic [13:0]           since;
        logic [5:0]            win_left;
        logic [23:0]           peak;
        rrd_det_state_type     st;
    } rrd_top_state_type;

    rrd_top_state_type s;
    rrd_top_state_type next_s;

    logic [2:0]  link_sync;
    logic        sclk_s;
    logic        csb_s;
    logic        sdi_s;
    rrd_mem_if   mem_bus ();

    // link pins cross into the reference clock domain first
    rrd_link_sync #(
        .WIDTH (3)
    ) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_async   ({i_sclk, i_csb_n, i_sdi}),
        .o_sync    (link_sync)
    );

    rrd_sample_mem u_mem (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .mem       (mem_bus)
    );

    assign sclk_s = link_sync[2];
    assign csb_s  = link_sync[1];
    assign sdi_s  = link_sync[0];

    // configuration fields
    logic [3:0]  f_win;
    logic [3:0]  f_gain;
    logic        f_en;
    logic [1:0]  f_pavg;
    logic [3:0]  f_ptsf;
    logic [5:0]  f_hoff;
    logic [1:0]  f_ravg;
    logic [2:0]  f_rhsf;
    assign f_win  = s.cfg_a[WIN_LSB+:4];
    assign f_gain = s.cfg_a[GAIN_LSB+:4];
    assign f_en   = s.cfg_a[EN_BIT];
    assign f_pavg = s.cfg_a[PAVG_LSB+:2];
    assign f_ptsf = s.cfg_a[PTSF_LSB+:4];
    assign f_hoff = s.cfg_b[HOFF_LSB+:6];
    assign f_ravg = s.cfg_b[RAVG_LSB+:2];
    assign f_rhsf = s.cfg_b[RHSF_LSB+:3];

    // detector arithmetic
    logic        det_on;
    logic [17:0] mag;
    logic [31:0] wide;
    logic [23:0] scaled;
    logic [28:0] thr_prod;
    logic [23:0] threshold;
    logic [16:0] dyn_prod;
    logic [13:0] dyn_hold;
    logic [13:0] holdoff;
    logic [5:0]  win_units;
    logic [2:0]  pk_shift;
    logic [2:0]  iv_shift;
    logic [27:0] pk_sum;
    logic [17:0] iv_sum;
    logic [23:0] peak_now;

    assign det_on   = f_en & i_channel_enable;
    assign mag      = i_sample_voltage[17] ? 18'(-i_sample_voltage)
                                           : i_sample_voltage;
    // auto-scale keeps unity gain: no range search on such a small budget
    assign wide     = (f_gain == GAIN_AUTO) ? {14'h0, mag}
                                            : ({14'h0, mag} << f_gain);
    assign scaled   = (|wide[31:24]) ? SCALED_MAX : wide[23:0];
    assign thr_prod = 29'(s.peak_avg) * 29'({1'b0, f_ptsf} + 5'h01);
    assign threshold = thr_prod[27:4];
    assign dyn_prod = 17'(s.int_avg) * 17'(f_rhsf);
    assign dyn_hold = dyn_prod[16:3];
    assign holdoff  = ({8'h00, f_hoff} > dyn_hold) ? {8'h00, f_hoff}
                                                   : dyn_hold;
    assign win_units = {1'b0, f_win, 1'b0} + WIN_BASE;
    assign pk_shift = {1'b0, f_pavg} + 3'h1;
    assign iv_shift = {1'b0, f_ravg} + 3'h1;
    assign peak_now = (s.st == DET_WINDOW && i_sample_valid
                       && scaled > s.peak) ? scaled : s.peak;
    // weighted averages: (new + (W-1)*avg) / W with W a power of two
    assign pk_sum   = ({4'h0, peak_now} + ({4'h0, s.peak_avg} << pk_shift)
                       - {4'h0, s.peak_avg}) >> pk_shift;
    assign iv_sum   = ({4'h0, s.since} + ({4'h0, s.int_avg} << iv_shift)
                       - {4'h0, s.int_avg}) >> iv_shift;

    // link edges and buffer handshakes
    logic        rise;
    logic        fall;
    logic [7:0]  cmd_full;
    logic [23:0] din_full;
    logic        fifo_word;
    logic        pop;
    logic        push;
    logic        full_hit;
    logic [5:0]  thr_eff;
    logic [23:0] word;
    logic [2:0]  tag;

    assign rise     = sclk_s & ~s.sclk_prev;
    assign fall     = ~sclk_s & s.sclk_prev;
    assign cmd_full = {s.cmd[6:0], sdi_s};
    assign din_full = {s.din[22:0], sdi_s};
    assign fifo_word = (s.cmd[7:1] == ADDR_BURST)
                     | (s.cmd[7:1] == ADDR_SINGLE);
    // a word that went out as empty or overflow is not consumed
    assign pop      = ~csb_s & rise & (s.bit_cnt == CNT_FRAME_END)
                    & s.is_read & fifo_word & s.word_valid;
    assign full_hit = i_sample_valid & (s.count == FIFO_FULL) & ~pop;
    assign push     = i_sample_valid & ~full_hit & ~i_fifo_clear;
    assign thr_eff  = (i_fifo_irq_threshold == 6'h00) ? 6'h01
                    : (i_fifo_irq_threshold > FIFO_FULL) ? FIFO_FULL
                    : i_fifo_irq_threshold;

    // sample tag chosen when the word is handed to the shifter
    always_comb begin
        tag = mem_bus.rd_data[5:3];
        if (s.ovf) begin
            tag = TAG_OVERFLOW;
        end else if (s.count == 6'h00) begin
            tag = TAG_EMPTY;
        end else if (s.count == 6'h01) begin
            tag = mem_bus.rd_data[5:3] | TAG_LAST_BIT;
        end
    end

    // read word selected by the command address
    always_comb begin
        case (s.cmd[7:1])
            ADDR_CFG_A:    word = s.cfg_a;
            ADDR_CFG_B:    word = s.cfg_b;
            ADDR_BURST,
            ADDR_SINGLE:   word = {(s.count == 6'h00 || s.ovf)
                                   ? 18'h0 : mem_bus.rd_data[23:6],
                                   tag, mem_bus.rd_data[2:0]};
            ADDR_INTERVAL: word = {s.beat_interval, 10'h000};
            default:       word = 24'h000000;
        endcase
    end

    // buffer write side; stored tag is only valid or fast
    assign mem_bus.wr_en   = push;
    assign mem_bus.wr_addr = s.wr_ptr;
    assign mem_bus.wr_data = {i_sample_voltage,
                              i_sample_fast ? TAG_FAST : TAG_VALID,
                              i_pace_tag};
    assign mem_bus.rd_addr = s.rd_ptr;

    // next state of link, registers, buffer and detector
    always_comb begin
        next_s           = s;
        next_s.sclk_prev = sclk_s;

        // serial link: command byte, then 24 data bits per word
        if (csb_s) begin
            next_s.bit_cnt     = 6'h00;
            next_s.sdo_oe      = 1'b0;
            next_s.reload_pend = 1'b0;
        end else begin
            next_s.sdo_oe = s.is_read & (s.bit_cnt >= CNT_DATA_0);
            if (rise) begin
                if (s.bit_cnt < CNT_DONE) begin
                    next_s.bit_cnt = s.bit_cnt + 6'h01;
                end
                if (s.bit_cnt < CNT_DATA_0) begin
                    next_s.cmd = cmd_full;
                    if (s.bit_cnt == CNT_CMD_LAST) begin
                        next_s.is_read     = cmd_full[0];
                        next_s.burst       = cmd_full[7:1] == ADDR_BURST;
                        next_s.reload_pend = cmd_full[0];
                    end
                end else if (s.bit_cnt < CNT_DONE) begin
                    next_s.din = din_full;
                end
                if (s.bit_cnt == CNT_FRAME_END) begin
                    if (s.is_read && s.burst) begin
                        // burst: next 24 edges carry the next sample
                        next_s.bit_cnt     = CNT_DATA_0;
                        next_s.reload_pend = 1'b1;
                    end
                    if (!s.is_read && s.cmd[7:1] == ADDR_CFG_A) begin
                        next_s.cfg_a = din_full & CFG_A_MASK;
                    end
                    if (!s.is_read && s.cmd[7:1] == ADDR_CFG_B) begin
                        next_s.cfg_b = din_full & CFG_B_MASK;
                    end
                end
            end
            // load on a falling edge so memory read data has settled
            if (fall && s.reload_pend) begin
                next_s.sdo         = word[23];
                next_s.shreg       = {word[22:0], 1'b0};
                next_s.reload_pend = 1'b0;
                next_s.word_valid  = fifo_word & (s.count != 6'h00) & ~s.ovf;
            end else if (fall && s.is_read && s.bit_cnt >= CNT_DATA_0) begin
                next_s.sdo   = s.shreg[23];
                next_s.shreg = {s.shreg[22:0], 1'b0};
            end
        end

        // buffer pointers and occupancy
        if (i_fifo_clear) begin
            next_s.wr_ptr = '0;
            next_s.rd_ptr = '0;
            next_s.count  = 6'h00;
            next_s.ovf    = 1'b0;
        end else begin
            if (push) begin
                next_s.wr_ptr = s.wr_ptr + 5'h01;
            end
            if (pop) begin
                next_s.rd_ptr = s.rd_ptr + 5'h01;
            end
            next_s.count = s.count + {5'h00, push} - {5'h00, pop};
            if (full_hit) begin
                next_s.ovf = 1'b1;
            end
        end
        next_s.fifo_irq = next_s.count >= thr_eff;

        // interval counter in detector time units, saturating
        if (i_beat_tick && s.since != INTERVAL_MAX) begin
            next_s.since = s.since + 14'h0001;
        end

        // beat detector: cross threshold after hold-off, track peak
        if (i_fifo_clear || !det_on) begin
            next_s.st    = DET_IDLE;
            next_s.peak  = 24'h000000;
            if (i_fifo_clear) begin
                next_s.since    = 14'h0000;
                next_s.peak_avg = 24'h000000;
                next_s.int_avg  = 14'h0000;
            end
        end else begin
            case (s.st)
                DET_IDLE: begin
                    if (i_sample_valid && s.since >= holdoff
                        && scaled > threshold) begin
                        next_s.st       = DET_WINDOW;
                        next_s.peak     = scaled;
                        next_s.win_left = win_units;
                    end
                end
                DET_WINDOW: begin
                    next_s.peak = peak_now;
                    if (i_beat_tick) begin
                        next_s.win_left = s.win_left - 6'h01;
                    end
                    if (s.win_left == 6'h00) begin
                        next_s.st            = DET_IDLE;
                        next_s.beat_interval = s.since;
                        next_s.since         = 14'h0000;
                        next_s.peak_avg      = pk_sum[23:0];
                        next_s.int_avg       = iv_sum[13:0];
                        next_s.peak          = 24'h000000;
                    end
                end
                default: begin
                    next_s.st = DET_IDLE;
                end
            endcase
        end

        // interval interrupt: a new beat wins over a same-cycle clear
        if (s.st == DET_WINDOW && s.win_left == 6'h00 && det_on
            && !i_fifo_clear) begin
            next_s.beat_irq = 1'b1;
        end else if (i_beat_irq_clear) begin
            next_s.beat_irq = 1'b0;
        end
    end

    // single state register
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            s           <= '0;
            s.sclk_prev <= 1'b1; // synchroniser resets high
            s.cfg_a     <= CFG_A_RESET;
            s.cfg_b     <= CFG_B_RESET;
            s.st        <= DET_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from flip-flops
    assign o_sdo                = s.sdo;
    assign o_sdo_oe             = s.sdo_oe;
    assign o_fifo_irq           = s.fifo_irq;
    assign o_fifo_overflow_flag = s.ovf;
    assign o_beat_interval_irq  = s.beat_irq;
endmodule // rrd_beat_fifo
`default_nettype wire

// ==== bench/rrd_beat_fifo_chk.sv ====
// port checker for the beat detector and sample buffer block
`timescale 1ns/1ps
`default_nettype none
module rrd_beat_fifo_chk (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_sclk,
    input wire logic i_csb_n,
    input wire logic o_sdo,
    input wire logic o_sdo_oe,
    input wire logic i_sample_valid,
    input wire logic i_channel_enable,
    input wire logic i_fifo_clear,
    input wire logic o_fifo_irq,
    input wire logic o_fifo_overflow_flag,
    input wire logic o_beat_interval_irq
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    // a clear then a quiet cycle must leave no unread entry behind
    sequence s_clear_quiet;
        i_fifo_clear ##1 !i_sample_valid;
    endsequence
    // the sync lag is at most four cycles, so six idle cycles is safe
    chk_oe_idle: assert property (i_csb_n [*6] |-> !o_sdo_oe)
        else $error("sdo driven while deselected");
    chk_oe_late: assert property ($rose(o_sdo_oe) |-> !$past(i_csb_n, 4))
        else $error("sdo enabled too early");
    chk_sdo_hold: assert property (i_sclk [*4] |-> $stable(o_sdo))
        else $error("sdo moved while clock high");
    chk_ovf_hold: assert property (o_fifo_overflow_flag && !i_fifo_clear
        |=> o_fifo_overflow_flag)
        else $error("overflow flag not sticky");
    chk_ovf_clear: assert property (i_fifo_clear |=> !o_fifo_overflow_flag)
        else $error("overflow kept after clear");
    chk_ovf_cause: assert property ($rose(o_fifo_overflow_flag)
        |-> $past(i_sample_valid))
        else $error("overflow without a write");
    chk_irq_clear: assert property (s_clear_quiet |=> !o_fifo_irq)
        else $error("buffer irq after clear");
    chk_irq_cause: assert property ($rose(o_fifo_irq)
        |-> $past(i_sample_valid))
        else $error("buffer irq without a write");
    chk_irq_drop: assert property ($fell(o_fifo_irq)
        |-> $past(i_fifo_clear) || !$past(i_csb_n, 2))
        else $error("buffer irq fell without a read");
    chk_beat_gate: assert property (!i_channel_enable [*3]
        |-> !$rose(o_beat_interval_irq))
        else $error("beat irq with channel off");
endmodule // rrd_beat_fifo_chk
bind rrd_beat_fifo rrd_beat_fifo_chk u_chk (.i_ref_clk, .i_reset, .i_sclk,
    .i_csb_n, .o_sdo, .o_sdo_oe, .i_sample_valid, .i_channel_enable,
    .i_fifo_clear, .o_fifo_irq, .o_fifo_overflow_flag, .o_beat_interval_irq);
`default_nettype wire

// ==== bench/rrd_host_model.sv ====
// serial host model: drives frames and collects the answer bits
`timescale 1ns/1ps
`default_nettype none
module rrd_host_model (
    output var  logic o_sclk,
    output var  logic o_csb_n,
    output var  logic o_sdi,
    input  wire logic i_sdo
);
    // idle link: clock rests low, select high
    initial begin
        o_sclk = 1'b0;
        o_csb_n = 1'b1;
        o_sdi = 1'b0;
    end
    // frame of n rising edges, 48 ns period, data changes after a fall
    task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd,
                        input int n, output logic [71:0] rd);
        logic [31:0] fr;
        fr = {cmd, wd};
        rd = '0;
        o_csb_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            o_sdi = (i < 32) ? fr[31 - i] : ~o_sdi;
            #24 o_sclk = 1'b1;
            rd = {rd[70:0], i_sdo};
            #24 o_sclk = 1'b0;
        end
        #24 o_csb_n = 1'b1;
        o_sdi = ~o_sdi; // released line must not look like live data
        #96;
    endtask
endmodule // rrd_host_model
`default_nettype wire

// ==== bench/tb.sv ====
// self-checking bench for the beat detector and sample buffer block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        i_ref_clk = 1'b0;
    logic        i_reset = 1'b1;
    logic        sclk, csb_n, sdi, sdo, sdo_oe;
    logic        fifo_irq, ovf, beat_irq, chan = 1'b0, tick = 1'b0;
    logic        valid = 1'b0;
    logic        fast = 1'b0;
    logic        clear = 1'b0;
    logic [17:0] volt = 18'h00000;
    logic [2:0]  pace = 3'h0;
    logic [5:0]  thr = 6'h01;
    logic [71:0] rd;
    int          fail_count = 0;
    int          total_checks = 0;
    // 200 MHz reference clock
    always #2.5 i_ref_clk = ~i_ref_clk;
    // beat irq clear stays low
    rrd_beat_fifo dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .i_sclk(sclk), .i_csb_n(csb_n), .i_sdi(sdi), .o_sdo(sdo),
        .o_sdo_oe(sdo_oe), .i_sample_valid(valid), .i_sample_voltage(volt),
        .i_sample_fast(fast), .i_pace_tag(pace), .i_channel_enable(chan),
        .i_beat_tick(tick), .i_fifo_clear(clear),
        .i_fifo_irq_threshold(thr), .i_beat_irq_clear(1'b0),
        .o_fifo_irq(fifo_irq), .o_fifo_overflow_flag(ovf),
        .o_beat_interval_irq(beat_irq));
    rrd_host_model host (.o_sclk(sclk), .o_csb_n(csb_n), .o_sdi(sdi),
        .i_sdo(sdo_oe ? sdo : ~sdo)); // undriven: inverse
    // shared compare
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        if (fail_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // one sample pulse, then time for the flags to settle
    task automatic push(input logic [17:0] v, input logic f,
                        input logic [2:0] p);
        @(negedge i_ref_clk);
        valid = 1'b1;
        volt = v;
        fast = f;
        pace = p;
        @(negedge i_ref_clk);
        valid = 1'b0;
        repeat (2) @(negedge i_ref_clk);
    endtask
    task automatic t_config();
        host.xfer(8'h3B, 24'h000000, 32, rd);
        check(rd[23:0], 24'h3F2300);
        host.xfer(8'h3D, 24'h000000, 32, rd);
        check(rd[23:0], 24'h202400);
        host.xfer(8'h3A, 24'hFFFFFF, 32, rd);
        host.xfer(8'h3C, 24'hFFFFFF, 32, rd);
        host.xfer(8'h7E, 24'hFFFFFF, 32, rd);
        host.xfer(8'h3B, 24'h000000, 32, rd);
        check(rd[23:0], 24'hFFBF00);
        host.xfer(8'h3D, 24'h000000, 32, rd);
        check(rd[23:0], 24'h3F3700);
        host.xfer(8'h7F, 24'h000000, 32, rd);
        check(rd[23:0], 24'h000000);
        host.xfer(8'h4B, 24'h000000, 32, rd);
        check(rd[23:0], 24'h000000);
    endtask
    task automatic t_single();
        thr = 6'h02;
        push(18'h2A5C3, 1'b0, 3'h5);
        check({23'h0, fifo_irq}, 24'h000000);
        push(18'h1234F, 1'b1, 3'h2);
        check({23'h0, fifo_irq}, 24'h000001);
        host.xfer(8'h43, 24'h000000, 32, rd);
        check(rd[23:0], {18'h2A5C3, 3'h0, 3'h5});
        check({23'h0, fifo_irq}, 24'h000000);
        host.xfer(8'h43, 24'h000000, 32, rd);
        check(rd[23:0], {18'h1234F, 3'h3, 3'h2});
        host.xfer(8'h43, 24'h000000, 32, rd);
        check({3'h0, rd[23:3]}, 24'h000006);
    endtask
    task automatic t_burst();
        push(18'h00001, 1'b0, 3'h1);
        push(18'h3FFFF, 1'b1, 3'h7);
        push(18'h20000, 1'b0, 3'h0);
        host.xfer(8'h41, 24'h000000, 80, rd);
        check(rd[71:48], {18'h00001, 3'h0, 3'h1});
        check(rd[47:24], {18'h3FFFF, 3'h1, 3'h7});
        check(rd[23:0], {18'h20000, 3'h2, 3'h0});
        host.xfer(8'h43, 24'h000000, 32, rd);
        check({3'h0, rd[23:3]}, 24'h000006);
    endtask
    task automatic t_overflow();
        thr = 6'h20;
        for (int i = 0; i < 32; i++) begin
            push(18'(i), 1'b0, 3'h0);
        end
        check({22'h0, fifo_irq, ovf}, 24'h000002);
        push(18'h15555, 1'b0, 3'h0);
        check({22'h0, fifo_irq, ovf}, 24'h000003);
        host.xfer(8'h43, 24'h000000, 32, rd);
        check({3'h0, rd[23:3]}, 24'h000007);
        // the host must clear the buffer before trusting data again
        @(negedge i_ref_clk);
        clear = 1'b1;
        @(negedge i_ref_clk);
        clear = 1'b0;
        repeat (2) @(negedge i_ref_clk);
        check({22'h0, fifo_irq, ovf}, 24'h000000);
        host.xfer(8'h43, 24'h000000, 32, rd);
        check({3'h0, rd[23:3]}, 24'h000006);
    endtask
    task automatic t_beat();
        chan = 1'b1;
        for (int i = 0; i < 99; i++) begin
            if (i == 63) push(18'h00100, 1'b0, 3'h0);
            @(negedge i_ref_clk) tick = 1'b1;
            @(negedge i_ref_clk) tick = 1'b0;
        end
        host.xfer(8'h4B, 24'h000000, 32, rd);
        check(rd[23:0], {14'h0063, 10'h000});
        check({23'h0, beat_irq}, 24'h000001);
    endtask
    // main sequence: reset for two cycles, settle, run the scenarios
    initial begin
        repeat (2) @(negedge i_ref_clk);
        i_reset = 1'b0;
        repeat (3) @(negedge i_ref_clk);
        t_config();
        t_single();
        t_burst();
        t_overflow();
        t_beat();
        give_verdict();
    end
    // watchdog: the scenarios need well under 100 us
    initial begin
        #300000;
        fail_count++;
        give_verdict();
    end
endmodule // tb
`default_nettype wire
